// file: verilog/rsp_defines.svh
`ifndef RSP_DEFINES_SVH
`define RSP_DEFINES_SVH

// Register indices on the plain register port
`define RSP_REG_CTRL        4'h0
`define RSP_REG_FRAME       4'h1
`define RSP_REG_WDATA       4'h2
`define RSP_REG_RDATA       4'h3
`define RSP_REG_STATUS      4'h4

// Control register fields
`define RSP_CTRL_PINSEL     0
`define RSP_CTRL_HWCLK      1
`define RSP_CTRL_CE         2
`define RSP_CTRL_TXMODE     3
`define RSP_CTRL_TXEN       4
`define RSP_CTRL_RESET      16'h0000

// Frame register fields
`define RSP_FRM_ADDR_LSB    0
`define RSP_FRM_ADDR_MSB    4
`define RSP_FRM_DIR         5
`define RSP_FRM_HDR_LSB     6
`define RSP_FRM_HDR_MSB     8
`define RSP_FRM_FAST        9

// Status register fields
`define RSP_ST_BUSY         0
`define RSP_ST_SYNC         1
`define RSP_ST_CE           2

// Frame layout
`define RSP_HDR_NORMAL      3'h5
`define RSP_FRAME_BITS      25
`define RSP_CMD_BITS        9
`define RSP_CELL_LOAD       5'h19
`define RSP_CELL_LAST       5'h1a
`define RSP_CELL_RX_FIRST   5'h09
`define RSP_CELL_RX_LAST    5'h18

// Shift clock timing
`define RSP_SYS_CLK_MHZ     50
`define RSP_SCLK_HALF_NS    125
`define RSP_SCLK_HALF_CYC   ((`RSP_SCLK_HALF_NS * `RSP_SYS_CLK_MHZ) / 1000)

// Synchroniser width: reference clock, serial data, modem bit
`define RSP_SYNC_W          3

`endif

// file: verilog/rsp_pkg.sv
package rsp_pkg;

    // Serial engine states
    typedef enum logic [0:0] {
        RSP_IDLE,
        RSP_RUN
    } rsp_state_t;

endpackage

// file: verilog/rsp_sync.sv
`timescale 1ns/1ps
`include "rsp_defines.svh"

module rsp_sync
    import rsp_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic [`RSP_SYNC_W-1:0]  async_in,
    output logic      [`RSP_SYNC_W-1:0]  sync_out
);

    logic [`RSP_SYNC_W-1:0] meta_q;

    // Two flops; the first is read only by the second
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// file: verilog/rsp_port.sv
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "rsp_defines.svh"

// What this block does
// RULE_01: Each access is 25 bits: header, direction, 5-bit address, 16 data.
// RULE_02: Normal frames carry header 101b.
// RULE_03: All fields go out most significant bit first.
// RULE_04: Device alone drives shift clock and load strobe.
// RULE_05: Direction zero makes the radio write the data into the register.
// RULE_06: Write data changes on falling edges, radio samples on rising.
// RULE_07: Radio loads the word on the rising edge after strobe rises.
// RULE_08: Read data changes on rising edges, device samples on falling.
// RULE_09: In a read the radio drives the data field; device lets go.
// RULE_10: Device captures read word at first falling edge with strobe high.
// RULE_11: Radio releases at next rise; device drives after following rise.
// RULE_12: Reads always return 16 bits, unimplemented bits undefined.
// RULE_13: Modem bit line high after reset, timed by 12 MHz radio clock.
// RULE_14: Receive mode: sync low while correlating, high once synced.
// RULE_15: Transmit mode: sync high enables transmitter, low disables it.
// RULE_16: Radio powers down with chip enable low but still serves frames.
// RULE_17: Link sleep forces chip enable low only if clock control enabled.
// RULE_18: Radio pins float after reset until software selects them.
// RULE_19: Fast-write mode lets header carry other values.
// RULE_20: Load strobe stays low while shifting, rises only at frame end.

module rsp_port
    import rsp_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [15:0] REG_RDATA,
    input  wire logic        TX_BIT,
    input  wire logic        RX_SYNC_FOUND,
    input  wire logic        LINK_SLEEP,
    input  wire logic        RADIO_REFERENCE_CLOCK,
    input  wire logic        MODEM_BIT_LINE_I,
    output logic             MODEM_BIT_LINE_O,
    output logic             MODEM_BIT_LINE_OE,
    output logic             MODEM_RX_BIT,
    output logic             SYNC_TX_ENABLE_O,
    output logic             SYNC_TX_ENABLE_OE,
    output logic             RADIO_CHIP_ENABLE_O,
    output logic             RADIO_CHIP_ENABLE_OE,
    output logic             SHIFT_CLK_O,
    output logic             SHIFT_CLK_OE,
    input  wire logic        SERIAL_DATA_LINE_I,
    output logic             SERIAL_DATA_LINE_O,
    output logic             SERIAL_DATA_LINE_OE,
    output logic             LOAD_STROBE_O,
    output logic             LOAD_STROBE_OE
);

    localparam logic [7:0] HALF_CYC = 8'(`RSP_SCLK_HALF_CYC);

    // Cell decode shared by sampling and line ownership
    function automatic logic in_rx_cell(input logic [4:0] c);
        in_rx_cell = (c >= `RSP_CELL_RX_FIRST) && (c <= `RSP_CELL_RX_LAST);
    endfunction

    function automatic logic radio_owns(input logic [4:0] c);
        radio_owns = (c >= `RSP_CELL_RX_FIRST);
    endfunction

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [15:0] ctrl_q;
    logic [9:0]  frame_cmd_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic [15:0] rd_mux;
    logic [15:0] rdata_out_q;

    // Serial engine state
    rsp_state_t  state_q;
    logic [7:0]  div_q;
    logic [4:0]  cell_q;
    logic        half_q;
    logic        is_read_q;
    logic [24:0] shift_q;
    logic [15:0] rx_shift_q;
    logic        sclk_q;
    logic        serial_data_line_q;
    logic        sle_q;

    // Modem state
    logic        modem_q;
    logic        modem_rx_q;
    logic        ref_prev_q;

    // Synchronised pin inputs
    logic [`RSP_SYNC_W-1:0] pins_async;
    logic [`RSP_SYNC_W-1:0] pins_sync;
    logic        ref_s;
    logic        serial_data_line_s;
    logic        modem_s;

    // ------------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------------
    wire pin_function_select = ctrl_q[`RSP_CTRL_PINSEL];
    wire hw_clk_ctrl         = ctrl_q[`RSP_CTRL_HWCLK];
    wire sw_chip_enable      = ctrl_q[`RSP_CTRL_CE];
    wire tx_mode             = ctrl_q[`RSP_CTRL_TXMODE];
    wire tx_enable           = ctrl_q[`RSP_CTRL_TXEN];

    wire wr_ctrl   = REG_WR && (REG_ADDR == `RSP_REG_CTRL);
    wire wr_frame  = REG_WR && (REG_ADDR == `RSP_REG_FRAME);
    wire wr_wdata  = REG_WR && (REG_ADDR == `RSP_REG_WDATA);
    wire busy      = (state_q == RSP_RUN);
    wire start     = wr_frame && !busy;
    wire tick      = busy && (div_q == HALF_CYC - 8'h01);
    wire rise_tick = tick && !half_q;
    wire fall_tick = tick && half_q;
    wire last_cell = (cell_q == `RSP_CELL_LAST);
    wire [4:0] next_cell = cell_q + 5'h01;

    // Header: fixed pattern unless fast write asks otherwise
    wire [2:0] hdr_sel = REG_WDATA[`RSP_FRM_FAST] ?
        REG_WDATA[`RSP_FRM_HDR_MSB:`RSP_FRM_HDR_LSB] :
        `RSP_HDR_NORMAL;                                // RULE_02 RULE_19
    wire       dir_sel = REG_WDATA[`RSP_FRM_DIR];
    wire [4:0] addr_sel =
        REG_WDATA[`RSP_FRM_ADDR_MSB:`RSP_FRM_ADDR_LSB];

    // Frame image, header in the top bits so it leaves first
    wire [24:0] frame_img =
        {hdr_sel, dir_sel, addr_sel, wdata_q};                 // RULE_01

    // Read window: radio owns the data line from the data field on
    wire radio_window = busy && is_read_q
        && radio_owns(cell_q);                                 // RULE_09
    wire sample_now   = fall_tick && is_read_q
        && in_rx_cell(cell_q);                                 // RULE_08
    wire capture_now  = fall_tick && is_read_q
        && (cell_q == `RSP_CELL_LOAD);                         // RULE_10

    // ------------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------------
    assign pins_async = {MODEM_BIT_LINE_I, SERIAL_DATA_LINE_I,
                         RADIO_REFERENCE_CLOCK};
    assign ref_s   = pins_sync[0];
    assign serial_data_line_s  = pins_sync[1];
    assign modem_s = pins_sync[2];

    rsp_sync u_sync (
        .clk      (SYS_CLK),
        .rst_b    (RST_B),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    // Rising edge of the radio clock, seen in the system domain
    wire ref_rise = ref_s && !ref_prev_q;

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Control, frame command and write data
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            ctrl_q      <= `RSP_CTRL_RESET;
            frame_cmd_q <= '0;
            wdata_q     <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= REG_WDATA;
            end
            // Frame register frozen during a frame, keeps status honest
            if (start) begin
                frame_cmd_q <= REG_WDATA[9:0];
            end
            if (wr_wdata && !busy) begin
                wdata_q <= REG_WDATA;
            end
        end
    end

    // Read mux; unmapped indices read zero
    always_comb begin
        case (REG_ADDR)
            `RSP_REG_CTRL:   rd_mux = ctrl_q;
            `RSP_REG_FRAME:  rd_mux = {6'h00, frame_cmd_q};
            `RSP_REG_WDATA:  rd_mux = wdata_q;
            `RSP_REG_RDATA:  rd_mux = rdata_q;
            `RSP_REG_STATUS: rd_mux = {13'h0000,
                                      RADIO_CHIP_ENABLE_O,
                                      RX_SYNC_FOUND, busy};
            default:         rd_mux = 16'h0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            rdata_out_q <= '0;
        end else begin
            rdata_out_q <= REG_RD ? rd_mux : 16'h0000;
        end
    end

    assign REG_RDATA = rdata_out_q;

    // ------------------------------------------------------------------
    // Serial engine: 27 cells, each one low half then one high half
    // ------------------------------------------------------------------
    // Half-period divider; restarts with each frame
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            div_q <= '0;
        end else if (!busy || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // State, cell count and clock phase
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            state_q   <= RSP_IDLE;
            cell_q    <= '0;
            half_q    <= 1'b0;
            is_read_q <= 1'b0;
        end else begin
            case (state_q)
                RSP_IDLE: begin
                    half_q <= 1'b0;
                    cell_q <= '0;
                    if (start) begin
                        state_q   <= RSP_RUN;
                        is_read_q <= dir_sel;                  // RULE_05
                    end
                end
                RSP_RUN: begin
                    if (tick) begin
                        half_q <= !half_q;
                    end
                    if (fall_tick) begin
                        cell_q <= next_cell;
                        // Device takes the line back only here
                        if (last_cell) begin
                            state_q <= RSP_IDLE;               // RULE_11
                        end
                    end
                end
                default: begin
                    state_q <= RSP_IDLE;
                end
            endcase
        end
    end

    // Shift clock: rises mid-cell, falls at the cell boundary
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            sclk_q <= 1'b0;
        end else if (rise_tick) begin
            sclk_q <= 1'b1;                                    // RULE_04
        end else if (fall_tick || !busy) begin
            sclk_q <= 1'b0;
        end
    end

    // Outgoing frame; new bit set on each falling edge
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            shift_q <= '0;
            serial_data_line_q  <= 1'b0;
        end else if (start) begin
            shift_q <= {frame_img[23:0], 1'b0};
            serial_data_line_q  <= frame_img[24];                          // RULE_03
        end else if (fall_tick) begin
            shift_q <= {shift_q[23:0], 1'b0};
            serial_data_line_q  <= shift_q[24];                            // RULE_06
        end
    end

    // Load strobe high only across the load cell
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            sle_q <= 1'b0;
        end else if (fall_tick) begin
            sle_q <= (next_cell == `RSP_CELL_LOAD);            // RULE_20
        end else if (!busy) begin
            sle_q <= 1'b0;
        end
    end

    // Read data in, captured word held for software
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            rx_shift_q <= '0;
            rdata_q    <= '0;
        end else begin
            if (sample_now) begin
                rx_shift_q <= {rx_shift_q[14:0], serial_data_line_s};      // RULE_03
            end
            // All 16 bits kept, whatever the register width
            if (capture_now) begin
                rdata_q <= rx_shift_q;                         // RULE_12
            end
        end
    end

    // ------------------------------------------------------------------
    // Modem path, paced by the radio clock edges
    // ------------------------------------------------------------------
    // The radio clock is only sampled, so the bit lags by up to 3 cycles
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            ref_prev_q <= 1'b0;
            modem_q    <= 1'b1;                                // RULE_13
            modem_rx_q <= 1'b0;
        end else begin
            ref_prev_q <= ref_s;
            if (ref_rise) begin
                modem_q    <= tx_mode ? TX_BIT : 1'b1;         // RULE_13
                modem_rx_q <= modem_s;
            end
        end
    end

    assign MODEM_BIT_LINE_O  = modem_q;
    // Dedicated pin: driven from reset, released only to receive
    assign MODEM_BIT_LINE_OE = tx_mode || !pin_function_select;
    assign MODEM_RX_BIT      = modem_rx_q;

    // ------------------------------------------------------------------
    // Sync and chip enable
    // ------------------------------------------------------------------
    wire sync_rx  = RX_SYNC_FOUND;                             // RULE_14
    wire sync_tx  = tx_enable;                                 // RULE_15
    wire sleep_ce = hw_clk_ctrl && LINK_SLEEP;                 // RULE_17

    assign SYNC_TX_ENABLE_O    = tx_mode ? sync_tx : sync_rx;
    assign RADIO_CHIP_ENABLE_O = sw_chip_enable && !sleep_ce;

    // ------------------------------------------------------------------
    // Pin drive, all gated by the pin function select
    // ------------------------------------------------------------------
    assign SYNC_TX_ENABLE_OE    = pin_function_select;        // RULE_18
    assign RADIO_CHIP_ENABLE_OE = pin_function_select;        // RULE_18
    assign SHIFT_CLK_O          = sclk_q;
    assign SHIFT_CLK_OE         = pin_function_select;        // RULE_04
    assign LOAD_STROBE_O        = sle_q;                      // RULE_07
    assign LOAD_STROBE_OE       = pin_function_select;        // RULE_04
    assign SERIAL_DATA_LINE_O   = serial_data_line_q;
    assign SERIAL_DATA_LINE_OE  = pin_function_select
        && !radio_window;                                     // RULE_09

endmodule

// file: verification/rsp_port_asserts.sv
`timescale 1ns/1ps

module rsp_port_asserts (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [15:0] REG_RDATA,
    input  wire logic        RX_SYNC_FOUND,
    input  wire logic        LINK_SLEEP,
    input  wire logic        MODEM_BIT_LINE_O,
    input  wire logic        SYNC_TX_ENABLE_O,
    input  wire logic        SYNC_TX_ENABLE_OE,
    input  wire logic        RADIO_CHIP_ENABLE_O,
    input  wire logic        RADIO_CHIP_ENABLE_OE,
    input  wire logic        SHIFT_CLK_O,
    input  wire logic        SHIFT_CLK_OE,
    input  wire logic        SERIAL_DATA_LINE_O,
    input  wire logic        SERIAL_DATA_LINE_OE,
    input  wire logic        LOAD_STROBE_O,
    input  wire logic        LOAD_STROBE_OE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    logic       sclk_q;
    logic       tail_q;
    logic [4:0] rise_q;

    // Shift clock rises per frame; the trailing rise after the strobe is
    // skipped so it cannot leak into the next frame's count
    always_ff @(posedge SYS_CLK) begin
        sclk_q <= SHIFT_CLK_O;
        if (!RST_B || LOAD_STROBE_O) begin
            rise_q <= 5'h00;
            tail_q <= LOAD_STROBE_O;
        end else if (SHIFT_CLK_O && !sclk_q) begin
            tail_q <= 1'b0;
            rise_q <= tail_q ? rise_q : rise_q + 5'h01;
        end
    end

    // Pin ownership
    rst_pins_a: assert property (
        $rose(RST_B) |-> !SHIFT_CLK_OE && !LOAD_STROBE_OE
        && !SERIAL_DATA_LINE_OE && !SYNC_TX_ENABLE_OE
        && !RADIO_CHIP_ENABLE_OE && MODEM_BIT_LINE_O)
        else $error("radio pins not released at reset");
    pin_select_a: assert property (
        $changed(SHIFT_CLK_OE) |-> $past(REG_WR)
        && LOAD_STROBE_OE == SHIFT_CLK_OE)
        else $error("pin drive changed without register write");
    // Shift clock shape and data launch
    sclk_high_a: assert property (
        $rose(SHIFT_CLK_O) |-> SHIFT_CLK_O [*6] ##1 !SHIFT_CLK_O)
        else $error("shift clock high phase wrong");
    sclk_low_a: assert property (
        $fell(SHIFT_CLK_O) |-> !SHIFT_CLK_O [*6])
        else $error("shift clock low phase wrong");
    data_launch_a: assert property (
        SERIAL_DATA_LINE_OE && $changed(SERIAL_DATA_LINE_O) |-> !SHIFT_CLK_O)
        else $error("data changed while shift clock high");
    frame_len_a: assert property (
        $rose(LOAD_STROBE_O) |-> rise_q == 5'h19)
        else $error("frame did not carry 25 bits");
    strobe_cell_a: assert property (
        $rose(LOAD_STROBE_O) |-> ##11 LOAD_STROBE_O ##1 !LOAD_STROBE_O)
        else $error("load strobe width wrong");
    // Read turnaround
    rd_release_a: assert property (
        $fell(SERIAL_DATA_LINE_OE) && SHIFT_CLK_OE |-> $fell(SHIFT_CLK_O))
        else $error("data line released off a falling edge");
    rd_retake_a: assert property (
        $rose(SERIAL_DATA_LINE_OE) && $past(SHIFT_CLK_OE)
        |-> $past(LOAD_STROBE_O, 13) && !$past(LOAD_STROBE_O, 12))
        else $error("data line retaken at wrong time");
    // Register port and control pins
    rdata_idle_a: assert property (
        !$past(REG_RD) |-> REG_RDATA == 16'h0000)
        else $error("read data outside its cycle");
    ce_cause_a: assert property (
        $changed(RADIO_CHIP_ENABLE_O) |-> $changed(LINK_SLEEP) || $past(REG_WR))
        else $error("chip enable moved without cause");
    sync_cause_a: assert property (
        $changed(SYNC_TX_ENABLE_O) |-> $changed(RX_SYNC_FOUND) || $past(REG_WR))
        else $error("sync output moved without cause");

    wr_end_c: cover property ($rose(LOAD_STROBE_O) && SERIAL_DATA_LINE_OE);
    rd_turn_c: cover property ($fell(SERIAL_DATA_LINE_OE) && SHIFT_CLK_OE);
    sleep_ce_c: cover property ($fell(RADIO_CHIP_ENABLE_O) && LINK_SLEEP);
endmodule

bind rsp_port rsp_port_asserts u_rsp_port_asserts (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .RX_SYNC_FOUND(RX_SYNC_FOUND),
    .LINK_SLEEP(LINK_SLEEP), .MODEM_BIT_LINE_O(MODEM_BIT_LINE_O),
    .SYNC_TX_ENABLE_O(SYNC_TX_ENABLE_O), .SYNC_TX_ENABLE_OE(SYNC_TX_ENABLE_OE),
    .RADIO_CHIP_ENABLE_O(RADIO_CHIP_ENABLE_O),
    .RADIO_CHIP_ENABLE_OE(RADIO_CHIP_ENABLE_OE),
    .SHIFT_CLK_O(SHIFT_CLK_O), .SHIFT_CLK_OE(SHIFT_CLK_OE),
    .SERIAL_DATA_LINE_O(SERIAL_DATA_LINE_O),
    .SERIAL_DATA_LINE_OE(SERIAL_DATA_LINE_OE),
    .LOAD_STROBE_O(LOAD_STROBE_O), .LOAD_STROBE_OE(LOAD_STROBE_OE));

// file: verification/rsp_radio_model.sv
`timescale 1ns/1ps

// Serial slave; only listens to shift clock and strobe
module rsp_radio_model (
    input  wire logic        clk,
    input  wire logic        sclk,
    input  wire logic        load_strobe,
    input  wire logic        dev_data,
    input  wire logic        dev_drive,
    output logic             line,
    output logic             ref_clk,
    output logic [24:0]      frame_q,
    output int               frames
);
    logic [15:0] mem [32];
    logic [24:0] sh_q = '0;
    int          cnt = 0;
    logic        tail_q = 1'b0;
    logic        rd_q = 1'b0;
    logic        drv_q = 1'b0;
    logic        drv_oe_q = 1'b0;
    logic        idle_q = 1'b0;

    // Free-running reference clock, phase unrelated to the system clock
    initial begin
        ref_clk = 1'b0;
        frame_q = '0;
        frames = 0;
        #7;
        forever #80 ref_clk = ~ref_clk;
    end

    // Released line shows the inverse of its last driven level
    always @(posedge clk) if (dev_drive || drv_oe_q) idle_q <= line;
    assign line = dev_drive ? dev_data : (drv_oe_q ? drv_q : ~idle_q);

    // Answers with chip enable low too; any header accepted
    always @(posedge sclk) begin
        if (tail_q) begin
            tail_q <= 1'b0;
            cnt <= 0;
            rd_q <= 1'b0;
        end else if (load_strobe) begin
            if (cnt == 25 && !rd_q) mem[sh_q[20:16]] <= sh_q[15:0];
            drv_oe_q <= 1'b0;
            frame_q <= sh_q;
            frames <= frames + 1;
            tail_q <= 1'b1;
        end else if (cnt >= 9 && rd_q) begin
            // Always 16 bits out, changed on the rise
            drv_oe_q <= 1'b1;
            drv_q <= mem[sh_q[4:0]][4'(24 - cnt)];
            cnt <= cnt + 1;
        end else begin
            sh_q <= {sh_q[23:0], line};
            if (cnt == 8) rd_q <= sh_q[4];
            cnt <= cnt + 1;
        end
    end
endmodule

// file: verification/radio_serial_register_port_tb.sv
`timescale 1ns/1ps
`include "rsp_defines.svh"

module radio_serial_register_port_tb;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        tx_bit = 1'b0;
    logic        rx_sync = 1'b0;
    logic        sleep = 1'b0;
    logic        modem_in = 1'b0;
    logic [15:0] rdata, rd_v, lf, dv;
    logic [4:0]  av;
    logic        mo, moe, mrx, so, soe, co, coe, ko, koe;
    logic        dout, doe, lo, loe, line, ref_clk;
    logic [24:0] frame;
    int          frames, f0;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;

    always #10 sys_clk = ~sys_clk;

    rsp_port DUT (
        .SYS_CLK(sys_clk), .RST_B(rst_b), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(rdata), .TX_BIT(tx_bit), .RX_SYNC_FOUND(rx_sync),
        .LINK_SLEEP(sleep), .RADIO_REFERENCE_CLOCK(ref_clk),
        .MODEM_BIT_LINE_I(moe ? mo : modem_in), .MODEM_BIT_LINE_O(mo),
        .MODEM_BIT_LINE_OE(moe), .MODEM_RX_BIT(mrx),
        .SYNC_TX_ENABLE_O(so), .SYNC_TX_ENABLE_OE(soe),
        .RADIO_CHIP_ENABLE_O(co), .RADIO_CHIP_ENABLE_OE(coe),
        .SHIFT_CLK_O(ko), .SHIFT_CLK_OE(koe), .SERIAL_DATA_LINE_I(line),
        .SERIAL_DATA_LINE_O(dout), .SERIAL_DATA_LINE_OE(doe),
        .LOAD_STROBE_O(lo), .LOAD_STROBE_OE(loe));

    // Undriven shift clock and strobe read as low at the radio
    rsp_radio_model radio (
        .clk(sys_clk), .sclk(koe === 1'b1 && ko === 1'b1),
        .load_strobe(loe === 1'b1 && lo === 1'b1), .dev_data(dout),
        .dev_drive(doe), .line(line), .ref_clk(ref_clk),
        .frame_q(frame), .frames(frames));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [24:0] seen, input logic [24:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_v = rdata;
    endtask

    // One frame; a second start while busy must be ignored
    task automatic run_frame(input logic [9:0] f, input logic [15:0] d,
                             input logic [24:0] exp);
        int n;
        n = 0;
        f0 = frames;
        wr(`RSP_REG_WDATA, d);
        wr(`RSP_REG_FRAME, {6'h00, f});
        wr(`RSP_REG_FRAME, {6'h00, ~f});
        do begin
            rd(`RSP_REG_STATUS);
            n++;
        end while (rd_v[`RSP_ST_BUSY] !== 1'b0 && n < 250);
        chk(25'(frames - f0), 25'h1);
        chk(f[5] ? {16'h0000, frame[8:0]} : frame, exp);
    endtask

    task automatic results();
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard, far above the expected run of some 5200 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            $display("FAIL %0t run did not finish", $time);
            results();
        end
    end

    initial begin
        lf = 16'h3649;
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1 chk({koe, coe, soe, doe, loe, moe, mo, ko, lo, rdata},
               {9'h00c, 16'h0000});
        // Every combination of the four control bits above pin select against sleep and sync inputs
        for (int i = 0; i < 64; i++) begin
            @(posedge sys_clk) rx_sync <= i[4];
            sleep <= i[5];
            wr(`RSP_REG_CTRL, {11'h000, i[3:0], 1'b1});
            #1 chk({koe, soe, coe, loe, so, co}, {4'hf, i[2] ? i[3] : i[4],
                   i[1] & ~(i[0] & i[5])});
            rd(`RSP_REG_STATUS);
            chk(rd_v[2:1], {i[1] & ~(i[0] & i[5]), i[4]});
        end
        // Unmapped places ignore writes and read as zero
        for (int a = 5; a < 16; a++) begin
            lf = lfsr(lf);
            wr(4'(a), lf);
            rd(4'(a));
            chk(rd_v, 25'h0);
        end
        // Write then read back, radio powered down, extremes first
        wr(`RSP_REG_CTRL, 16'h0001);
        for (int k = 0; k < 6; k++) begin
            lf = lfsr(lf);
            av = k == 0 ? 5'h1f : (k == 1 ? 5'h00 : lf[4:0]);
            dv = k == 0 ? 16'hffff : (k == 1 ? 16'h0000 : lfsr(lf));
            run_frame({1'b0, lf[12:10], 1'b0, av}, dv,
                      {3'h5, 1'b0, av, dv});
            run_frame({4'h0, 1'b1, av}, 16'h0000,
                      {16'h0000, 3'h5, 1'b1, av});
            rd(`RSP_REG_RDATA);
            chk(rd_v, dv);
        end
        run_frame({1'b1, 3'h3, 1'b0, 5'h02}, lf, {3'h3, 1'b0, 5'h02, lf});
        // Modem line follows the transmit bit in transmit mode
        wr(`RSP_REG_CTRL, 16'h0009);
        for (int k = 0; k < 8; k++) begin
            lf = lfsr(lf);
            @(posedge sys_clk) tx_bit <= lf[0];
            repeat (30) @(posedge sys_clk);
            #1 chk({moe, mo}, {1'b1, lf[0]});
        end
        // Receive mode releases the pin and samples it
        wr(`RSP_REG_CTRL, 16'h0001);
        for (int k = 0; k < 8; k++) begin
            lf = lfsr(lf);
            @(posedge sys_clk) modem_in <= lf[1];
            repeat (30) @(posedge sys_clk);
            #1 chk({moe, mo, mrx}, {2'b01, lf[1]});
        end
        results();
    end
endmodule
